// ### design/stepper_seq_pkg.sv
// Constants, register map and carrier types for the phase sequencer
package stepper_seq_pkg;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_PS     = 5000;
    localparam int PIN_FILTER_NS     = 1000;
    localparam int PIN_FILTER_CYCLES = (PIN_FILTER_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

    // ------------------------------------------------------------
    // Sequencer geometry: 64 positions per electrical turn
    // ------------------------------------------------------------
    localparam int          POS_W      = 6;
    localparam logic [5:0]  POS_RESET  = 6'h08;
    localparam logic [5:0]  A_ON_LO    = 6'h31;
    localparam logic [5:0]  A_ON_HI    = 6'h0F;
    localparam logic [5:0]  AB_ON_LO   = 6'h11;
    localparam logic [5:0]  AB_ON_HI   = 6'h2F;
    localparam logic [5:0]  B_ON_LO    = 6'h01;
    localparam logic [5:0]  B_ON_HI    = 6'h1F;
    localparam logic [5:0]  BB_ON_LO   = 6'h21;
    localparam logic [5:0]  BB_ON_HI   = 6'h3F;

    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [7:0]  CONTROL_ADDR    = 8'h00;
    localparam logic [7:0]  STATUS_ADDR     = 8'h04;
    localparam logic [7:0]  STEP_COUNT_ADDR = 8'h08;
    localparam logic [31:0] CONTROL_RESET   = 32'h0000_0001;
    localparam int          CTRL_RUN_BIT    = 0;
    localparam int          STAT_POS_LSB    = 0;
    localparam int          STAT_MODE_LSB   = 8;
    localparam int          STAT_ENA_BIT    = 16;
    localparam int          STAT_RST_BIT    = 17;
    localparam int          STAT_PHASE_LSB  = 20;
    localparam logic [1:0]  RESP_OKAY       = 2'b00;
    localparam logic [1:0]  RESP_SLVERR     = 2'b10;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic [4:0] {
        MODE_TWO     = 5'b00001,
        MODE_ONE_TWO = 5'b00010,
        MODE_W12     = 5'b00100,
        MODE_2W12    = 5'b01000,
        MODE_4W12    = 5'b10000
    } excitation_mode_type;

    typedef struct packed {
        logic a;
        logic ab;
        logic b;
        logic bb;
    } phase_drive_type;

    typedef struct packed {
        logic step_clock;
        logic rotation_direction_select;
        logic excitation_select_low;
        logic excitation_select_high;
        logic step_edge_select;
        logic enable;
        logic reset_n;
    } control_pins_type;

endpackage : stepper_seq_pkg

// ### design/pin_conditioner.sv
// Two-flop synchroniser and per-bit glitch filter for control pins
`timescale 1ns/10ps
`default_nettype none
module pin_conditioner #(
    parameter int         WIDTH         = 7,
    parameter int         FILTER_CYCLES = 200,
    parameter logic [6:0] RESET_LEVEL   = 7'h00
) (
    // Clock and reset
    input  wire logic             i_clk,
    input  wire logic             i_srst,
    // Pins
    input  wire logic [WIDTH-1:0] i_pins,
    // Clean levels
    output logic      [WIDTH-1:0] o_levels
);

    localparam int CNT_W = $clog2(FILTER_CYCLES + 1);
    localparam logic [CNT_W-1:0] CNT_MAX = CNT_W'(FILTER_CYCLES - 1);

    genvar g;
    generate
        for (g = 0; g < WIDTH; g++) begin : g_bit
            logic             sync_first;
            logic             sync_second;
            logic [CNT_W-1:0] count;

            always_ff @(posedge i_clk) begin
                sync_first  <= i_pins[g];
                sync_second <= sync_first;
            end

            // A level change is accepted only after it has stood for the filter time
            always_ff @(posedge i_clk) begin
                if (i_srst) begin
                    count       <= '0;
                    o_levels[g] <= RESET_LEVEL[g];
                end else if (sync_second == o_levels[g]) begin
                    count <= '0;
                end else if (count == CNT_MAX) begin
                    count       <= '0;
                    o_levels[g] <= sync_second;
                end else begin
                    count <= count + CNT_W'(1);
                end
            end
        end
    endgenerate

endmodule : pin_conditioner
`default_nettype wire

// ### design/stepper_phase_sequencer.sv
// Step clock driven phase sequencer with an AXI4-Lite status and control port
`timescale 1ns/10ps
`default_nettype none
module stepper_phase_sequencer
    import stepper_seq_pkg::*;
#(
    parameter int FILTER_CYCLES = stepper_seq_pkg::PIN_FILTER_CYCLES
) (
    // Clock and power-on reset
    input  wire logic                             i_clk,
    input  wire logic                             i_srst,
    // Control pins from the host controller
    input  wire stepper_seq_pkg::control_pins_type i_pins,
    // Phase drive outputs
    output stepper_seq_pkg::phase_drive_type      o_phase,
    // AXI4-Lite write address
    input  wire logic                             i_awvalid,
    output logic                                  o_awready,
    input  wire logic [7:0]                       i_awaddr,
    // AXI4-Lite write data
    input  wire logic                             i_wvalid,
    output logic                                  o_wready,
    input  wire logic [31:0]                      i_wdata,
    input  wire logic [3:0]                       i_wstrb,
    // AXI4-Lite write response
    output logic                                  o_bvalid,
    input  wire logic                             i_bready,
    output logic [1:0]                            o_bresp,
    // AXI4-Lite read address
    input  wire logic                             i_arvalid,
    output logic                                  o_arready,
    input  wire logic [7:0]                       i_araddr,
    // AXI4-Lite read data
    output logic                                  o_rvalid,
    input  wire logic                             i_rready,
    output logic [31:0]                           o_rdata,
    output logic [1:0]                            o_rresp
);

    // ------------------------------------------------------------
    // Pin conditioning
    // ------------------------------------------------------------
    control_pins_type    pins;
    logic                step_prev;
    logic [POS_W-1:0]    position;
    logic [POS_W-1:0]    next_position;
    logic [POS_W-1:0]    increment;
    excitation_mode_type mode;
    logic [31:0]         control;
    logic [31:0]         step_count;
    logic                running;
    logic                seq_reset;
    logic                step_event;
    phase_drive_type     next_phase;

    pin_conditioner #(
        .WIDTH         (7),
        .FILTER_CYCLES (FILTER_CYCLES),
        .RESET_LEVEL   (7'h01)
    ) u_pins (
        .i_clk    (i_clk),
        .i_srst   (i_srst),
        .i_pins   (i_pins),
        .o_levels (pins)
    );

    // ------------------------------------------------------------
    // Mode decode and stepping
    // ------------------------------------------------------------
    assign seq_reset = i_srst || !pins.reset_n;
    assign running   = pins.enable && control[CTRL_RUN_BIT];

    always_comb begin
        case ({pins.step_edge_select, pins.excitation_select_high, pins.excitation_select_low})
            3'b100:  mode = MODE_TWO;
            3'b101:  mode = MODE_ONE_TWO;
            3'b110:  mode = MODE_W12;
            3'b111:  mode = MODE_2W12;
            3'b000:  mode = MODE_ONE_TWO;
            3'b001:  mode = MODE_W12;
            3'b010:  mode = MODE_2W12;
            3'b011:  mode = MODE_4W12;
            default: mode = MODE_ONE_TWO;
        endcase
    end

    always_comb begin
        case (mode)
            MODE_TWO:     increment = 6'h10;
            MODE_ONE_TWO: increment = 6'h08;
            MODE_W12:     increment = 6'h04;
            MODE_2W12:    increment = 6'h02;
            MODE_4W12:    increment = 6'h01;
            default:      increment = 6'h08;
        endcase
    end

    // Rising edge always steps; falling edge steps only with the edge bit low
    assign step_event = running && (pins.step_clock != step_prev)
                        && (pins.step_clock || !pins.step_edge_select);

    always_comb begin
        if (pins.rotation_direction_select) begin
            next_position = position - increment;
        end else begin
            next_position = position + increment;
        end
    end

    // Step clock history freezes while disabled; a level change still standing at re-enable steps then
    always_ff @(posedge i_clk) begin
        if (seq_reset) begin
            step_prev <= 1'b0;
        end else if (running) begin
            step_prev <= pins.step_clock;
        end
    end

    always_ff @(posedge i_clk) begin
        if (seq_reset) begin
            position <= POS_RESET;
        end else if (step_event) begin
            position <= next_position;
        end
    end

    always_ff @(posedge i_clk) begin
        if (seq_reset) begin
            step_count <= '0;
        end else if (step_event) begin
            step_count <= step_count + 32'h0000_0001;
        end
    end

    // ------------------------------------------------------------
    // Phase outputs
    // ------------------------------------------------------------
    // On-window of each winding spans all positions of one current sign
    always_comb begin
        next_phase.a  = (position >= A_ON_LO) || (position <= A_ON_HI);
        next_phase.ab = (position >= AB_ON_LO) && (position <= AB_ON_HI);
        next_phase.b  = (position >= B_ON_LO) && (position <= B_ON_HI);
        next_phase.bb = (position >= BB_ON_LO) && (position <= BB_ON_HI);
    end

    always_ff @(posedge i_clk) begin
        if (seq_reset || !running) begin
            o_phase <= '0;
        end else begin
            o_phase <= next_phase;
        end
    end

    // ------------------------------------------------------------
    // AXI4-Lite write path
    // ------------------------------------------------------------
    logic       aw_held;
    logic       w_held;
    logic [7:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic       do_write;

    assign do_write = aw_held && w_held && !o_bvalid;

    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            aw_held   <= 1'b0;
            o_awready <= 1'b1;
            aw_addr   <= '0;
        end else if (o_awready && i_awvalid) begin
            aw_held   <= 1'b1;
            o_awready <= 1'b0;
            aw_addr   <= i_awaddr;
        end else if (o_bvalid && i_bready) begin
            aw_held   <= 1'b0;
            o_awready <= 1'b1;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            w_held   <= 1'b0;
            o_wready <= 1'b1;
            w_data   <= '0;
            w_strb   <= '0;
        end else if (o_wready && i_wvalid) begin
            w_held   <= 1'b1;
            o_wready <= 1'b0;
            w_data   <= i_wdata;
            w_strb   <= i_wstrb;
        end else if (o_bvalid && i_bready) begin
            w_held   <= 1'b0;
            o_wready <= 1'b1;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            o_bvalid <= 1'b0;
            o_bresp  <= RESP_OKAY;
        end else if (do_write) begin
            o_bvalid <= 1'b1;
            o_bresp  <= (aw_addr == CONTROL_ADDR) ? RESP_OKAY : RESP_SLVERR;
        end else if (i_bready) begin
            o_bvalid <= 1'b0;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            control <= CONTROL_RESET;
        end else if (do_write && aw_addr == CONTROL_ADDR && w_strb[0]) begin
            control <= {31'h0000_0000, w_data[CTRL_RUN_BIT]};
        end
    end

    // ------------------------------------------------------------
    // AXI4-Lite read path
    // ------------------------------------------------------------
    logic [31:0] status;

    always_comb begin
        status                                     = '0;
        status[STAT_POS_LSB +: POS_W]              = position;
        status[STAT_MODE_LSB +: 5]                 = mode;
        status[STAT_ENA_BIT]                       = running;
        status[STAT_RST_BIT]                       = seq_reset;
        status[STAT_PHASE_LSB +: 4]                = o_phase;
    end

    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            o_arready <= 1'b1;
            o_rvalid  <= 1'b0;
            o_rdata   <= '0;
            o_rresp   <= RESP_OKAY;
        end else if (o_arready && i_arvalid) begin
            o_arready <= 1'b0;
            o_rvalid  <= 1'b1;
            o_rresp   <= RESP_OKAY;
            case (i_araddr)
                CONTROL_ADDR:    o_rdata <= control;
                STATUS_ADDR:     o_rdata <= status;
                STEP_COUNT_ADDR: o_rdata <= step_count;
                default: begin
                    o_rdata <= '0;
                    o_rresp <= RESP_SLVERR;
                end
            endcase
        end else if (o_rvalid && i_rready) begin
            o_arready <= 1'b1;
            o_rvalid  <= 1'b0;
        end
    end

endmodule : stepper_phase_sequencer
`default_nettype wire

// ### testbench/stepper_phase_sequencer_sva.sv
// Port checker for the phase sequencer
`timescale 1ns/10ps
`default_nettype none
module stepper_phase_sequencer_sva
    import stepper_seq_pkg::*;
#(
    parameter int FILTER_CYCLES = 200
) (
    // Clock and reset
    input wire logic                              i_clk,
    input wire logic                              i_srst,
    // Pins and phases
    input wire stepper_seq_pkg::control_pins_type i_pins,
    input wire stepper_seq_pkg::phase_drive_type  o_phase,
    // Register bus
    input wire logic                              i_awvalid,
    input wire logic                              o_awready,
    input wire logic                              i_wvalid,
    input wire logic                              o_wready,
    input wire logic                              o_bvalid,
    input wire logic                              i_bready,
    input wire logic [1:0]                        o_bresp,
    input wire logic                              i_arvalid,
    input wire logic                              o_arready,
    input wire logic                              o_rvalid,
    input wire logic                              i_rready,
    input wire logic [31:0]                       o_rdata,
    input wire logic [1:0]                        o_rresp
);
    // Pin to phase latency through synchroniser and filter
    localparam int LAT = FILTER_CYCLES + 6;
    int unsigned off_cnt;
    int unsigned rst_cnt;

    always_ff @(posedge i_clk) begin
        if (i_srst || i_pins.enable)
            off_cnt <= 0;
        else if (off_cnt < LAT)
            off_cnt <= off_cnt + 1;
    end

    always_ff @(posedge i_clk) begin
        if (i_srst || i_pins.reset_n)
            rst_cnt <= 0;
        else if (rst_cnt < LAT)
            rst_cnt <= rst_cnt + 1;
    end

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_srst);

    sequence s_wr_take;
        i_awvalid && o_awready && i_wvalid && o_wready;
    endsequence
    sequence s_wr_resp;
        !o_awready && !o_wready ##[1:2] o_bvalid;
    endsequence

    a_phase_off_disabled: assert property (off_cnt == LAT |-> o_phase == '0)
        else $error("phases on while disabled");
    a_phase_off_reset: assert property (rst_cnt == LAT |-> o_phase == '0)
        else $error("phases on while reset pin low");
    a_srst_init: assert property (disable iff (1'b0) $fell(i_srst) |->
        o_phase == '0 && o_awready && o_arready && !o_bvalid && !o_rvalid)
        else $error("state after power-on reset");
    a_opposed_off: assert property (
        !(o_phase.a && o_phase.ab) && !(o_phase.b && o_phase.bb))
        else $error("opposed windings on together");
    a_write_answer: assert property (s_wr_take |=> s_wr_resp)
        else $error("write response late");
    a_read_answer: assert property (i_arvalid && o_arready |=> o_rvalid && !o_arready)
        else $error("read response late");
    a_bresp_stands: assert property (o_bvalid && !i_bready |=> o_bvalid && $stable(o_bresp))
        else $error("write response dropped");
    a_rdata_stands: assert property (o_rvalid && !i_rready |=> o_rvalid && $stable(o_rdata))
        else $error("read data dropped");
endmodule : stepper_phase_sequencer_sva

bind stepper_phase_sequencer stepper_phase_sequencer_sva #(.FILTER_CYCLES(FILTER_CYCLES)) u_sva (
    .i_clk(i_clk), .i_srst(i_srst), .i_pins(i_pins), .o_phase(o_phase),
    .i_awvalid(i_awvalid), .o_awready(o_awready), .i_wvalid(i_wvalid), .o_wready(o_wready),
    .o_bvalid(o_bvalid), .i_bready(i_bready), .o_bresp(o_bresp), .i_arvalid(i_arvalid),
    .o_arready(o_arready), .o_rvalid(o_rvalid), .i_rready(i_rready), .o_rdata(o_rdata),
    .o_rresp(o_rresp));
`default_nettype wire

// ### testbench/stepper_ctrl_host.sv
// Host controller model driving the control pins
`timescale 1ns/10ps
`default_nettype none
module stepper_ctrl_host
    import stepper_seq_pkg::*;
#(
    parameter int HALF = 12
) (
    // Clock
    input  wire logic                             i_clk,
    // Control pins
    output var stepper_seq_pkg::control_pins_type o_pins
);
    initial o_pins = control_pins_type'(7'h01);

    task automatic idle(input int n);
        repeat (n) @(posedge i_clk);
    endtask : idle

    // Levels change only with a full half period before the next edge
    task automatic set_ctrl(input logic dir, input logic [2:0] m, input logic en, input logic rn);
        o_pins.rotation_direction_select <= dir;
        o_pins.step_edge_select          <= m[2];
        o_pins.excitation_select_high    <= m[1];
        o_pins.excitation_select_low     <= m[0];
        o_pins.enable                    <= en;
        o_pins.reset_n                   <= rn;
        idle(HALF);
    endtask : set_ctrl

    task automatic pulse();
        o_pins.step_clock <= 1'b1;
        idle(HALF);
        o_pins.step_clock <= 1'b0;
        idle(HALF);
    endtask : pulse
endmodule : stepper_ctrl_host
`default_nettype wire

// ### testbench/stepper_phase_sequencer_tb_top.sv
// Self-checking bench for the phase sequencer
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin bad_count++; \
    $display("wrong value at %0t: got %h expected %h", $time, g, e); end end
module stepper_phase_sequencer_tb_top;
    import stepper_seq_pkg::*;
    localparam int LIMIT = 20000;
    logic i_clk = 1'b0;
    logic i_srst = 1'b1;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0000_0000, rd;
    logic [3:0] wstrb = 4'hF;
    logic [1:0] rs;
    control_pins_type pins;
    phase_drive_type  o_phase;
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata;
    int bad_count = 0, checked = 0, cyc = 0, seed = 75, pos = 8, cnt = 0, idx = 0, i;

    always #2.5 i_clk = ~i_clk;

    stepper_ctrl_host #(.HALF(12)) u_host (.i_clk(i_clk), .o_pins(pins));
    stepper_phase_sequencer #(.FILTER_CYCLES(2)) u_dut (
        .i_clk(i_clk), .i_srst(i_srst), .i_pins(pins), .o_phase(o_phase),
        .i_awvalid(awvalid), .o_awready(awready), .i_awaddr(awaddr),
        .i_wvalid(wvalid), .o_wready(wready), .i_wdata(wdata), .i_wstrb(wstrb),
        .o_bvalid(bvalid), .i_bready(bready), .o_bresp(bresp),
        .i_arvalid(arvalid), .o_arready(arready), .i_araddr(araddr),
        .o_rvalid(rvalid), .i_rready(rready), .o_rdata(rdata), .o_rresp(rresp));

    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : finish_test

    always @(posedge i_clk) begin
        cyc++;
        if (cyc == LIMIT) begin
            bad_count++;
            finish_test();
        end
    end

    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        awvalid <= 1'b1; awaddr <= a; wvalid <= 1'b1; wdata <= d;
        do begin
            @(posedge i_clk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (!bvalid);
        bready <= 1'b1;
        @(posedge i_clk);
        r = bresp;
        bready <= 1'b0;
    endtask : axi_wr

    task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        arvalid <= 1'b1; araddr <= a;
        do begin
            @(posedge i_clk);
            if (arready) arvalid <= 1'b0;
        end while (!rvalid);
        rready <= 1'b1;
        @(posedge i_clk);
        d = rdata; r = rresp;
        rready <= 1'b0;
    endtask : axi_rd

    function automatic logic [3:0] ph_of(input int p);
        return {p >= 49 || p <= 15, p >= 17 && p <= 47, p >= 1 && p <= 31, p >= 33};
    endfunction : ph_of

    task automatic check_status();
        logic [31:0] e;
        e = 32'(pos) | (32'(1 << idx) << 8) | 32'h0001_0000 | (32'(ph_of(pos)) << 20);
        axi_rd(STATUS_ADDR, rd, rs);
        `CHK(rd, e)
        `CHK(o_phase, phase_drive_type'(ph_of(pos)))
        axi_rd(STEP_COUNT_ADDR, rd, rs);
        `CHK(rd, 32'(cnt))
    endtask : check_status

    // Steps the model beside the design; m is {edge bit, high, low}
    task automatic steps(input logic dir, input logic [2:0] m, input int n);
        int k;
        idx = int'(m[1:0]) + (m[2] ? 0 : 1);
        u_host.set_ctrl(dir, m, 1'b1, 1'b1);
        for (k = 0; k < n; k++) begin
            u_host.pulse();
            pos = (pos + (dir ? -1 : 1) * (16 >> idx) * (m[2] ? 1 : 2)) & 63;
            cnt += m[2] ? 1 : 2;
        end
        check_status();
    endtask : steps

    initial begin
        repeat (16) @(posedge i_clk);
        i_srst <= 1'b0;
        @(posedge i_clk);
        axi_rd(CONTROL_ADDR, rd, rs);
        `CHK(rd, CONTROL_RESET)
        axi_rd(8'hFC, rd, rs);
        `CHK(rs, RESP_SLVERR)
        `CHK(rd, 32'h0000_0000)
        axi_wr(STATUS_ADDR, 32'hFFFF_FFFF, rs);
        `CHK(rs, RESP_SLVERR)
        // A write without the low byte lane leaves the run bit alone
        wstrb <= 4'hE;
        axi_wr(CONTROL_ADDR, 32'h0000_0000, rs);
        wstrb <= 4'hF;
        `CHK(rs, RESP_OKAY)
        axi_rd(CONTROL_ADDR, rd, rs);
        `CHK(rd, CONTROL_RESET)
        $display("test registers done");
        for (i = 0; i < 8; i++)
            steps(1'($random(seed)), 3'(i), 1 + {$random(seed)} % 4);
        $display("test modes done");
        axi_wr(CONTROL_ADDR, 32'h0000_0000, rs);
        `CHK(rs, RESP_OKAY)
        u_host.pulse();
        axi_wr(CONTROL_ADDR, 32'h0000_0001, rs);
        check_status();
        $display("test run bit done");
        u_host.set_ctrl(1'b0, 3'b100, 1'b0, 1'b1);
        u_host.pulse();
        axi_rd(STATUS_ADDR, rd, rs);
        `CHK(rd[5:0], 6'(pos))
        `CHK(rd[16], 1'b0)
        `CHK(o_phase, phase_drive_type'(4'h0))
        // Reset pin low with enable high: only the reset can hold the phases off
        u_host.set_ctrl(1'b0, 3'b100, 1'b1, 1'b0);
        axi_rd(STATUS_ADDR, rd, rs);
        `CHK(rd[17], 1'b1)
        `CHK(o_phase, phase_drive_type'(4'h0))
        pos = 8;
        cnt = 0;
        u_host.set_ctrl(1'b0, 3'b100, 1'b1, 1'b1);
        idx = 0;
        check_status();
        steps(1'b1, 3'b100, 3);
        $display("test disable and reset done");
        finish_test();
    end
endmodule : stepper_phase_sequencer_tb_top
`default_nettype wire
